// [hw/serial_port_pkg.sv]
// constants shared by the serial port design files
package serial_port_pkg;
    localparam int DATA_W      = 16;
    localparam int CNT_W       = 5;
    localparam logic [CNT_W-1:0] WORD_BITS = 5'h10;
    localparam logic [CNT_W-1:0] BYTE_BITS = 5'h08;
    localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
    // data address map
    localparam logic [15:0] TX_HOLD_ADDR = 16'h0000;
    localparam logic [15:0] RX_HOLD_ADDR = 16'h0001;
    // tx_sync_source position inside status_word_one
    localparam int STATUS_SRC_POS = 2;
    // reset values
    localparam logic WIDTH_RESET = 1'b0;
    localparam logic SRC_RESET   = 1'b0;
    localparam logic REQ_RESET   = 1'b1;
    localparam logic [DATA_W-1:0] HOLD_RESET = 16'h0000;
    // pin indices into the sampled pin vector
    localparam int PIN_TXCLK = 0;
    localparam int PIN_TXFS  = 1;
    localparam int PIN_RXCLK = 2;
    localparam int PIN_RXFS  = 3;
    localparam int PIN_RXD   = 4;
    localparam int PIN_N     = 5;
endpackage : serial_port_pkg

// [hw/edge_sampler.sv]
// two-flop synchroniser with edge detection for one pin
`timescale 1ns/100ps
module edge_sampler (
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    input  wire logic pin_in,
    output wire logic level_out,
    output wire logic rise_out,
    output wire logic fall_out
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out  = sync_q & ~prev_q;
    assign fall_out  = ~sync_q & prev_q;
endmodule : edge_sampler

// [hw/double_buffered_sync_serial_port.sv]
// double-buffered synchronous serial port with holding registers at data addresses 0 and 1
`timescale 1ns/100ps
// What this block does
// - transmit and receive are separate logic, each with own clock and sync
// - bits leave on rising transmit clock, enter on falling receive clock
// - words go most significant bit first both ways
// - width select 0 moves 16-bit words, 1 moves 8-bit bytes
// - byte width uses only the low eight bits both ways
// - transmit holding register copied to shifter at each word start
// - full receive shifter copied to receive holding register
// - transfers start on frame sync unless continuous without sync
// - done interrupts on the next rising bit clock after the last bit
// - receive holding register keeps the old word until completion or a write to address 1
// - several writes before a load: only the last one is sent
// - reset clears sync source, floats data out, aborts transfers
// - reset clears width select, selecting 16-bit words
// - width select changes only by the set-width instruction
// - sync source 0 makes transmit sync an input, 1 drives pulses
// - sync source written by status-load, set and clear instructions
// - sync required 1 needs a sync per word, 0 runs without
// - sync required set and cleared by its own two instructions
// - transmit holding at address 0, receive holding at address 1
// - block-move reads of holding registers unsupported; shifters hidden
// - stopped bit clocks while idle do not disturb state
// - with driven sync, a write while idle brings a pulse on next rising clock
// - sync required and no reload: data output floats until reload
// - no sync required and no reload: last word repeats
// - byte receive moves the old low byte into the upper byte
module double_buffered_sync_serial_port #(
    parameter int ADDR_W = 16
) (
    input  wire logic                               sys_clk_in,
    input  wire logic                               reset_in,
    input  wire logic [ADDR_W-1:0]                  addr_in,
    input  wire logic                               wr_en_in,
    input  wire logic                               rd_en_in,
    input  wire logic                               block_move_instr_in,
    input  wire logic [serial_port_pkg::DATA_W-1:0] wr_data_in,
    output wire logic [serial_port_pkg::DATA_W-1:0] rd_data_out,
    input  wire logic                               set_width_instr_in,
    input  wire logic                               width_value_in,
    input  wire logic                               load_status_one_instr_in,
    input  wire logic [serial_port_pkg::DATA_W-1:0] status_word_one_in,
    input  wire logic                               set_sync_source_instr_in,
    input  wire logic                               clear_sync_source_instr_in,
    input  wire logic                               require_sync_instr_in,
    input  wire logic                               drop_sync_instr_in,
    input  wire logic                               tx_bit_clock_in,
    input  wire logic                               tx_frame_sync_in,
    output wire logic                               tx_frame_sync_out,
    output wire logic                               tx_frame_sync_oe_n_out,
    output wire logic                               tx_serial_out,
    output wire logic                               tx_serial_oe_n_out,
    input  wire logic                               rx_bit_clock_in,
    input  wire logic                               rx_frame_sync_in,
    input  wire logic                               rx_serial_in,
    output wire logic                               tx_done_irq_out,
    output wire logic                               rx_done_irq_out,
    output wire logic                               byte_width_select_out,
    output wire logic                               tx_sync_source_out,
    output wire logic                               sync_required_out
);
    import serial_port_pkg::*;

    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_ARMED, RX_SHIFT} rx_state_t;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    // pin sampling
    wire logic [PIN_N-1:0] pin_raw;
    wire logic [PIN_N-1:0] pin_lvl;
    wire logic [PIN_N-1:0] pin_rise;
    wire logic [PIN_N-1:0] pin_fall;

    assign pin_raw = {rx_serial_in, rx_frame_sync_in, rx_bit_clock_in,
                      tx_frame_sync_in, tx_bit_clock_in};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_pin
            edge_sampler u_sampler (
                .sys_clk_in (sys_clk_in),
                .reset_in   (reset_in),
                .pin_in     (pin_raw[gi]),
                .level_out  (pin_lvl[gi]),
                .rise_out   (pin_rise[gi]),
                .fall_out   (pin_fall[gi])
            );
        end
    endgenerate

    // mode bits
    logic width_sel_q;
    logic width_sel_d;
    logic sync_src_q;
    logic sync_src_d;
    logic sync_req_q;
    logic sync_req_d;

    assign width_sel_d = set_width_instr_in ? width_value_in : width_sel_q;
    assign sync_src_d = load_status_one_instr_in   ? status_word_one_in[STATUS_SRC_POS] :
                        set_sync_source_instr_in   ? 1'b1 :
                        clear_sync_source_instr_in ? 1'b0 : sync_src_q;
    assign sync_req_d = require_sync_instr_in ? 1'b1 :
                        drop_sync_instr_in    ? 1'b0 : sync_req_q;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            width_sel_q <= WIDTH_RESET;
            sync_src_q  <= SRC_RESET;
            sync_req_q  <= REQ_RESET;
        end else begin
            width_sel_q <= width_sel_d;
            sync_src_q  <= sync_src_d;
            sync_req_q  <= sync_req_d;
        end
    end

    // word length for the current width
    wire logic [CNT_W-1:0] word_len;
    assign word_len = width_sel_q ? BYTE_BITS : WORD_BITS;

    // data-memory access
    wire logic              sel_tx;
    wire logic              sel_rx;
    wire logic              wr_tx;
    wire logic              wr_rx;
    wire logic              rd_ok;
    wire logic [DATA_W-1:0] rd_data_d;
    logic      [DATA_W-1:0] rd_data_q;
    logic      [DATA_W-1:0] tx_hold_q;
    logic      [DATA_W-1:0] rx_hold_q;

    assign sel_tx    = addr_in == ADDR_W'(TX_HOLD_ADDR);
    assign sel_rx    = addr_in == ADDR_W'(RX_HOLD_ADDR);
    assign wr_tx     = wr_en_in & sel_tx;
    assign wr_rx     = wr_en_in & sel_rx;
    assign rd_ok     = rd_en_in & ~block_move_instr_in;
    assign rd_data_d = (rd_ok & sel_tx) ? tx_hold_q :
                       (rd_ok & sel_rx) ? rx_hold_q : '0;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    // transmit path
    tx_state_t         tx_state_q;
    logic [DATA_W-1:0] tx_shift_q;
    logic [CNT_W-1:0]  tx_cnt_q;
    logic              tx_full_q;
    logic              tx_fs_q;
    logic              tx_fs_seen_q;
    logic              tx_oe_n_q;
    logic              fs_oe_n_q;
    logic              tx_irq_q;

    wire logic              tx_rise;
    wire logic              tx_fall;
    wire logic              tx_fs_level;
    wire logic              tx_last;
    wire logic              tx_load;
    wire logic              tx_end;
    wire logic              tx_shift_en;
    wire logic              tx_fs_set;
    wire logic [DATA_W-1:0] tx_load_word;

    assign tx_rise      = pin_rise[PIN_TXCLK];
    assign tx_fall      = pin_fall[PIN_TXCLK];
    assign tx_fs_level  = sync_src_q ? tx_fs_q : pin_lvl[PIN_TXFS];
    assign tx_last      = tx_cnt_q == CNT_ZERO;
    // start on a seen sync, or reload at once when no sync is required
    assign tx_load      = tx_rise & ((tx_state_q == TX_IDLE & tx_fs_seen_q) |
                          (tx_state_q == TX_SHIFT & tx_last & (~sync_req_q | tx_fs_seen_q)));
    assign tx_end       = tx_rise & (tx_state_q == TX_SHIFT) & tx_last;
    assign tx_shift_en  = tx_rise & (tx_state_q == TX_SHIFT) & ~tx_last;
    // pulse after a write while idle, or during the final bit when a write is pending and sync is required
    assign tx_fs_set    = sync_src_q & tx_rise & tx_full_q & ~tx_fs_q &
                          ((tx_state_q == TX_IDLE) |
                           (tx_state_q == TX_SHIFT & sync_req_q & tx_cnt_q == CNT_ONE));
    assign tx_load_word = width_sel_q ? {tx_hold_q[7:0], 8'h00} : tx_hold_q;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tx_hold_q <= HOLD_RESET;
        end else if (wr_tx) begin
            tx_hold_q <= wr_data_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tx_state_q <= TX_IDLE;
            tx_shift_q <= '0;
            tx_cnt_q   <= CNT_ZERO;
        end else if (tx_load) begin
            tx_state_q <= TX_SHIFT;
            tx_shift_q <= tx_load_word;
            tx_cnt_q   <= word_len - CNT_ONE;
        end else if (tx_shift_en) begin
            tx_shift_q <= {tx_shift_q[DATA_W-2:0], 1'b0};
            tx_cnt_q   <= tx_cnt_q - CNT_ONE;
        end else if (tx_end) begin
            tx_state_q <= TX_IDLE;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tx_full_q <= 1'b0;
        end else begin
            tx_full_q <= wr_tx | (tx_full_q & ~tx_load);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tx_fs_q      <= 1'b0;
            tx_fs_seen_q <= 1'b0;
        end else begin
            if (tx_fs_set) begin
                tx_fs_q <= 1'b1;
            end else if (tx_rise | ~sync_src_q) begin
                tx_fs_q <= 1'b0;
            end
            if (tx_fall) begin
                tx_fs_seen_q <= tx_fs_level;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tx_oe_n_q  <= 1'b1;
            fs_oe_n_q  <= 1'b1;
            tx_irq_q   <= 1'b0;
        end else begin
            if (tx_load) begin
                tx_oe_n_q <= 1'b0;
            end else if (tx_end) begin
                tx_oe_n_q <= 1'b1;
            end
            fs_oe_n_q  <= ~sync_src_d;
            tx_irq_q   <= tx_end;
        end
    end

    // receive path
    rx_state_t         rx_state_q;
    logic [DATA_W-1:0] rx_shift_q;
    logic [CNT_W-1:0]  rx_cnt_q;
    logic              rx_pend_q;
    logic              rx_irq_q;

    wire logic              rx_fall;
    wire logic              rx_rise;
    wire logic              rx_fs_level;
    wire logic              rx_cap;
    wire logic              rx_done;
    wire logic [DATA_W-1:0] rx_cap_word;
    wire logic [DATA_W-1:0] rx_new_hold;

    assign rx_fall     = pin_fall[PIN_RXCLK];
    assign rx_rise     = pin_rise[PIN_RXCLK];
    assign rx_fs_level = pin_lvl[PIN_RXFS];
    assign rx_cap      = rx_fall & (rx_state_q != RX_IDLE);
    assign rx_done     = rx_fall & (rx_state_q == RX_SHIFT) & (rx_cnt_q == CNT_ONE);
    assign rx_cap_word = {rx_shift_q[DATA_W-2:0], pin_lvl[PIN_RXD]};
    assign rx_new_hold = width_sel_q ? {rx_hold_q[7:0], rx_cap_word[7:0]} : rx_cap_word;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rx_state_q <= RX_IDLE;
            rx_shift_q <= '0;
            rx_cnt_q   <= CNT_ZERO;
        end else if (rx_fall) begin
            if (rx_cap) begin
                rx_shift_q <= rx_cap_word;
            end
            unique case (rx_state_q)
                RX_IDLE: begin
                    if (rx_fs_level) begin
                        rx_state_q <= RX_ARMED;
                    end
                end
                RX_ARMED: begin
                    rx_state_q <= RX_SHIFT;
                    rx_cnt_q   <= word_len - CNT_ONE;
                end
                RX_SHIFT: begin
                    rx_cnt_q <= rx_cnt_q - CNT_ONE;
                    if (rx_done) begin
                        rx_state_q <= (~sync_req_q | rx_fs_level) ? RX_ARMED : RX_IDLE;
                    end
                end
                default: begin
                    rx_state_q <= RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rx_hold_q <= HOLD_RESET;
        end else if (rx_done) begin
            rx_hold_q <= rx_new_hold;
        end else if (wr_rx) begin
            rx_hold_q <= wr_data_in;
        end
    end

    // done held until the next rising receive clock; a new done wins over clear
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rx_pend_q <= 1'b0;
            rx_irq_q  <= 1'b0;
        end else begin
            rx_pend_q <= rx_done | (rx_pend_q & ~rx_rise);
            rx_irq_q  <= rx_pend_q & rx_rise;
        end
    end

    assign rd_data_out            = rd_data_q;
    assign tx_frame_sync_out      = tx_fs_q;
    assign tx_frame_sync_oe_n_out = fs_oe_n_q;
    assign tx_serial_out          = tx_shift_q[DATA_W-1];
    assign tx_serial_oe_n_out     = tx_oe_n_q;
    assign tx_done_irq_out        = tx_irq_q;
    assign rx_done_irq_out        = rx_irq_q;
    assign byte_width_select_out  = width_sel_q;
    assign tx_sync_source_out     = sync_src_q;
    assign sync_required_out      = sync_req_q;

    tx_irq_edge_a: assert property (
        tx_done_irq_out |-> $past(tx_rise) && $past(tx_state_q) == TX_SHIFT)
        else $error("tx done not tied to rising transmit clock");

    rx_irq_edge_a: assert property (
        rx_done_irq_out |-> $past(rx_rise) && $past(rx_pend_q))
        else $error("rx done not tied to rising receive clock");

    rx_hold_stable_a: assert property (
        !$stable(rx_hold_q) |-> $past(rx_done) || $past(wr_rx) || $past(reset_in))
        else $error("rx holding changed without completion or write");

    tx_out_edge_a: assert property (
        !$stable(tx_shift_q) |-> $past(tx_rise) || $past(reset_in))
        else $error("tx shifter moved off a rising clock");

    rx_cap_edge_a: assert property (
        !$stable(rx_shift_q) |-> $past(rx_fall) || $past(reset_in))
        else $error("rx shifter moved off a falling clock");

    reset_txm_a: assert property (
        @(posedge sys_clk_in) disable iff (1'b0)
        reset_in |=> !tx_sync_source_out && tx_serial_oe_n_out && tx_frame_sync_oe_n_out)
        else $error("reset left sync source set or data driven");

    reset_width_a: assert property (
        @(posedge sys_clk_in) disable iff (1'b0)
        reset_in |=> !byte_width_select_out)
        else $error("reset left byte width selected");

    width_instr_a: assert property (
        !$stable(width_sel_q) |-> $past(set_width_instr_in) || $past(reset_in))
        else $error("width select changed without its instruction");

    txm_instr_a: assert property (
        !$stable(sync_src_q) |-> $past(load_status_one_instr_in || set_sync_source_instr_in
                                  || clear_sync_source_instr_in) || $past(reset_in))
        else $error("sync source changed without an instruction");

    fsm_instr_a: assert property (
        !$stable(sync_req_q) |-> $past(require_sync_instr_in || drop_sync_instr_in)
                            || $past(reset_in))
        else $error("sync required changed without an instruction");

    block_move_a: assert property (
        rd_en_in && block_move_instr_in |=> rd_data_out == '0)
        else $error("block move read returned holding data");

    tx_load_copy_a: assert property (
        tx_load && !width_sel_q |=> tx_shift_q == $past(tx_hold_q))
        else $error("tx shifter not loaded from holding register");

    byte_move_a: assert property (
        rx_done && width_sel_q |=> rx_hold_q[15:8] == $past(rx_hold_q[7:0]))
        else $error("byte receive did not move old low byte up");

    float_a: assert property (
        tx_end && !tx_load && sync_req_q |=> tx_serial_oe_n_out [*2])
        else $error("data output not floated without reload");

    repeat_a: assert property (
        tx_end && !sync_req_q |=> !tx_serial_oe_n_out && tx_state_q == TX_SHIFT)
        else $error("continuous mode stopped without sync");

    sync_pulse_a: assert property (
        sync_src_q && tx_state_q == TX_IDLE && tx_full_q && !tx_fs_q && tx_rise
        |=> tx_frame_sync_out)
        else $error("no sync pulse after write with driven sync");
endmodule : double_buffered_sync_serial_port

// [bench/serial_codec_model.sv]
// far-side codec model: makes the bit clocks and the receive sync (transmit sync held low), sends and collects words
`timescale 1ns/100ps
module serial_codec_model (
    output logic      tx_clk_out,
    output logic      rx_clk_out,
    output logic      rx_fs_out,
    output logic      rx_dat_out,
    output logic      ext_fs_out,
    input  wire logic tx_dat_in,
    input  wire logic tx_oe_n_in
);
    // clocks stand low outside frames, so nothing starts while idle
    initial begin
        tx_clk_out = 1'b0;
        rx_clk_out = 1'b0;
        rx_fs_out  = 1'b0;
        rx_dat_out = 1'b0;
        ext_fs_out = 1'b0;
    end
    task automatic send(input logic [15:0] w, input int n);
        rx_fs_out = 1'b1;
        #400 rx_clk_out = 1'b1;
        #400 rx_clk_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            #400 rx_clk_out = 1'b1;
            rx_fs_out = 1'b0;
            rx_dat_out = w[i];
            #400 rx_clk_out = 1'b0;
        end
        // extra rise lets the done pulse out; data no longer valid
        #400 rx_clk_out = 1'b1;
        rx_dat_out = ~rx_dat_out;
        #400 rx_clk_out = 1'b0;
    endtask : send
    task automatic recv(input int n, output logic [15:0] w);
        int k;
        k = 0;
        w = 16'h0000;
        for (int p = 0; p < n + 4 && k < n; p++) begin
            #400 tx_clk_out = 1'b1;
            #400 tx_clk_out = 1'b0;
            if (tx_oe_n_in === 1'b0) begin
                w = {w[14:0], tx_dat_in};
                k++;
            end
        end
        #400 tx_clk_out = 1'b1;
        #400 tx_clk_out = 1'b0;
    endtask : recv
endmodule : serial_codec_model

// [bench/tb_double_buffered_sync_serial_port.sv]
// self-checking bench for the double-buffered serial port
`timescale 1ns/100ps
module tb_double_buffered_sync_serial_port;
    import serial_port_pkg::*;
    logic             clk;
    logic             rst;
    logic [15:0]      addr;
    logic             wr_en;
    logic             rd_en;
    logic             bm;
    logic [15:0]      wdat;
    logic             sw;
    logic             wv;
    logic             ls1;
    logic [15:0]      st1w;
    logic             ss;
    logic             cs;
    logic             rq;
    logic             drop_s;
    logic             rd_v;
    wire logic [15:0] rdat;
    wire logic        fs_o, fs_oe_n, dx, dx_oe_n, txi, rxi, bw, src, req;
    wire logic        tck, rck, rfs, rdt, efs, tx_fs_pin;
    logic [15:0]      exp_rd[$];
    logic [15:0]      exp_tx[$];
    logic [15:0]      txw;
    event             tx_ev;
    int               errors;
    int               n_tests;
    int               n_txi;
    int               n_rxi;

    double_buffered_sync_serial_port u_double_buffered_sync_serial_port (
        .sys_clk_in(clk), .reset_in(rst), .addr_in(addr), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .block_move_instr_in(bm), .wr_data_in(wdat), .rd_data_out(rdat),
        .set_width_instr_in(sw), .width_value_in(wv), .load_status_one_instr_in(ls1),
        .status_word_one_in(st1w), .set_sync_source_instr_in(ss),
        .clear_sync_source_instr_in(cs), .require_sync_instr_in(rq),
        .drop_sync_instr_in(drop_s),
        .tx_bit_clock_in(tck), .tx_frame_sync_in(tx_fs_pin), .tx_frame_sync_out(fs_o),
        .tx_frame_sync_oe_n_out(fs_oe_n), .tx_serial_out(dx), .tx_serial_oe_n_out(dx_oe_n),
        .rx_bit_clock_in(rck), .rx_frame_sync_in(rfs), .rx_serial_in(rdt),
        .tx_done_irq_out(txi), .rx_done_irq_out(rxi), .byte_width_select_out(bw),
        .tx_sync_source_out(src), .sync_required_out(req)
    );
    // sync pin level from whichever side drives it
    assign tx_fs_pin = fs_oe_n ? efs : fs_o;
    serial_codec_model u_serial_codec_model (
        .tx_clk_out(tck), .rx_clk_out(rck), .rx_fs_out(rfs), .rx_dat_out(rdt),
        .ext_fs_out(efs), .tx_dat_in(dx), .tx_oe_n_in(dx_oe_n)
    );

    always #50 clk = ~clk;

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        addr = a;
        wdat = d;
        wr_en = 1'b1;
        @(negedge clk) wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic b);
        addr = a;
        bm = b;
        rd_en = 1'b1;
        exp_rd.push_back(e);
        @(negedge clk) rd_en = 1'b0;
        bm = 1'b0;
        @(negedge clk);
    endtask : rd
    // one-cycle instruction strobe, then let the mode bit settle
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk) s = 1'b0;
        @(negedge clk);
    endtask : pulse

    always @(posedge clk) rd_v <= rd_en && !rst;
    always @(negedge clk) begin
        if (rd_v) chk(rdat, exp_rd.pop_front());
        if (txi === 1'b1) n_txi++;
        if (rxi === 1'b1) n_rxi++;
    end
    always @(tx_ev) chk(txw, exp_tx.pop_front());

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        wrap_up();
    end

    initial begin
        logic [15:0] v;
        logic [15:0] g;
        logic [7:0]  h;
        clk = 1'b0; rst = 1'b1; addr = 16'h0000; wr_en = 1'b0; rd_en = 1'b0;
        bm = 1'b0; wdat = 16'h0000; sw = 1'b0; wv = 1'b0; ls1 = 1'b0;
        st1w = 16'h0000; ss = 1'b0; cs = 1'b0; rq = 1'b0; drop_s = 1'b0;
        errors = 0; n_tests = 0; n_txi = 0; n_rxi = 0;
        void'($urandom(33714));
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk(bw, WIDTH_RESET);
        chk(src, 1'b0);
        chk(req, REQ_RESET);
        chk(dx_oe_n, 1'b1);
        v = 16'($urandom());
        wr(TX_HOLD_ADDR, v);
        rd(TX_HOLD_ADDR, v, 1'b0);
        rd(TX_HOLD_ADDR, 16'h0000, 1'b1);
        wr(16'h0005, ~v);
        rd(16'h0005, 16'h0000, 1'b0);
        rd(RX_HOLD_ADDR, 16'h0000, 1'b0);
        pulse(ss);
        chk(src, 1'b1);
        pulse(cs);
        chk(src, 1'b0);
        st1w = 16'h0004;
        pulse(ls1);
        chk(src, 1'b1);
        pulse(drop_s);
        chk(req, 1'b0);
        pulse(rq);
        chk(req, 1'b1);
        v = 16'($urandom());
        g = 16'($urandom());
        wr(TX_HOLD_ADDR, v);
        exp_tx.push_back(v);
        fork
            begin
                u_serial_codec_model.recv(16, txw);
                ->tx_ev;
            end
            u_serial_codec_model.send(g, 16);
            begin
                repeat (40) @(negedge clk);
                rd(RX_HOLD_ADDR, 16'h0000, 1'b0);
            end
        join
        repeat (10) @(negedge clk);
        chk(dx_oe_n, 1'b1);
        rd(RX_HOLD_ADDR, g, 1'b0);
        wv = 1'b1;
        pulse(sw);
        chk(bw, 1'b1);
        v = 16'($urandom());
        h = 8'($urandom());
        wr(TX_HOLD_ADDR, v);
        exp_tx.push_back({8'h00, v[7:0]});
        fork
            begin
                u_serial_codec_model.recv(8, txw);
                ->tx_ev;
            end
            u_serial_codec_model.send({8'h00, h}, 8);
        join
        repeat (10) @(negedge clk);
        rd(RX_HOLD_ADDR, {g[7:0], h}, 1'b0);
        wr(TX_HOLD_ADDR, v);
        fork
            u_serial_codec_model.recv(16, txw);
            begin
                repeat (60) @(negedge clk);
                rst = 1'b1;
                repeat (3) @(negedge clk);
                rst = 1'b0;
            end
        join
        chk(dx_oe_n, 1'b1);
        chk(src, 1'b0);
        chk(bw, 1'b0);
        rd(RX_HOLD_ADDR, HOLD_RESET, 1'b0);
        chk(16'(n_txi), 16'h0002);
        chk(16'(n_rxi), 16'h0002);
        wrap_up();
    end
endmodule : tb_double_buffered_sync_serial_port
